/* File: rtl/pofc_map.svh */
// Purpose: offsets, field positions and reset values of the PWM output
//          stage with fault control.
// Assumes: Avalon word addressing; byte address is four times the index.
// Notes:   in the override and fault-state fields pair x (0..2) uses bit 2x for its low pin, 2x+1 for high.
//
// Summary of operation
// - set pair-mode bit: independent pair, no dead time
// - independent pins: PWM, forced inactive or active
// - mode 10 gives edge single pulses on enable
// - duty match ends pair; period match ends all
// - override: six select bits high, six levels low
// - complementary override keeps complement and dead time
// - synced overrides apply only at timer boundaries
// - reset pins inactive if fuse 0, else released
// - separate polarity for high and low pins
// - per-pin enables; cleared pin released to GPIO
// - fault acts only on pairs enabled for it
// - six fault-state bits pick inactive or active
// - complementary fault: high side wins over low
// - latched: resume at boundary after pin high and flag cleared
// - cycle-by-cycle: resume at boundary after pin high
// - fault-mode bit picks latched or cycle-by-cycle
// - lockout bit blocks duty and period buffer loads
// - trigger when timer equals trigger compare value
// - direction bit picks counting phase in up/down
// - trigger postscaler ratio 1:1 to 1:16
// - postscaler cleared on compare write and reset
// - fault low in sleep raises wake interrupt
`ifndef POFC_MAP_SVH
`define POFC_MAP_SVH
`define POFC_A_CTL1     3'h0
`define POFC_A_CTL2     3'h1
`define POFC_A_OVR      3'h2
`define POFC_A_FLT      3'h3
`define POFC_A_TRIG     3'h4
`define POFC_A_STAT     3'h5
`define POFC_PENL_LSB   0
`define POFC_PENH_LSB   4
`define POFC_PAIR_MODE_BIT_LSB   8
`define POFC_UPDATE_LOCKOUT_BIT_BIT   0
`define POFC_OVERRIDE_SYNC_BIT_BIT  1
`define POFC_OPS_LSB    8
`define POFC_OLVL_LSB   0
`define POFC_OSEL_LSB   8
`define POFC_FEN_LSB    0
`define POFC_FST_LSB    8
`define POFC_FMODE_BIT  15
`define POFC_TDIR_BIT   15
`define POFC_FLAG_BIT   0
`define POFC_CTL2_RST   16'h0000
`define POFC_OVR_RST    16'h0000
`define POFC_FLT_RST    16'h0000
`define POFC_TRIG_RST   16'h0000
`endif

/* File: rtl/pofc_pair.sv */
// Purpose: resolves one output pair from compare, override and fault.
// Assumes: dead time is applied outside on the drive signal.
// Notes:   purely combinational; the top registers the result.
`timescale 1ns/1ps
module pofc_pair (
  pofc_pair_if.pair p
);
  logic o_h;  // high pin after override
  logic o_l;  // low pin after override

  // fault beats override, override beats compare
  always_comb
  begin
    o_h = p.osel_h ? p.olvl_h : p.cmp;
    o_l = p.osel_l ? p.olvl_l : p.cmp;
    // low forced active means high side takes the complement
    p.drive = p.osel_h ? p.olvl_h : (p.osel_l ? ~p.olvl_l : p.cmp);
    if (p.fon)
    begin
      p.act_h = p.fst_h;
      // in complementary pairs the high side keeps priority
      p.act_l = p.indep ? p.fst_l : (p.fst_l & ~p.fst_h);
    end
    else if (p.indep)
    begin
      // no dead time, both pins may be active together
      p.act_h = o_h;
      p.act_l = o_l;
    end
    else
    begin
      // dead time still applies to overridden outputs
      p.act_h = p.dt_h;
      p.act_l = p.dt_l;
    end
  end
endmodule // pofc_pair

/* File: rtl/pofc_pair_if.sv */
// Purpose: carries one pair's controls to its output resolver.
// Assumes: all signals active high, one clock domain.
// Notes:   act_h/act_l are active states before polarity.
`timescale 1ns/1ps
interface pofc_pair_if;
  logic indep;   // pair runs independently
  logic cmp;     // duty compare result
  logic dt_h;    // dead-timed high drive
  logic dt_l;    // dead-timed low drive
  logic osel_h;  // high pin overridden
  logic osel_l;  // low pin overridden
  logic olvl_h;  // override level, high pin
  logic olvl_l;  // override level, low pin
  logic fon;     // fault forcing this pair
  logic fst_h;   // fault state, high pin
  logic fst_l;   // fault state, low pin
  logic act_h;   // resolved high active
  logic act_l;   // resolved low active
  logic drive;   // drive toward dead-time unit
  modport ctl (output indep, cmp, dt_h, dt_l, osel_h, osel_l, olvl_h,
               olvl_l, fon, fst_h, fst_l, input act_h, act_l, drive);
  modport pair (input indep, cmp, dt_h, dt_l, osel_h, osel_l, olvl_h,
                olvl_l, fon, fst_h, fst_l, output act_h, act_l, drive);
endinterface // pofc_pair_if

/* File: rtl/pofc_pkg.sv */
// Purpose: shared types of the PWM output stage.
// Assumes: constants live in pofc_map.svh.
// Notes:   fault states are Gray coded along run, hold, wait.
package pofc_pkg;
  // time-base counting modes
  typedef enum logic [1:0] {
    TB_FREE   = 2'h0,
    TB_UPDN   = 2'h1,
    TB_SINGLE = 2'h2,
    TB_UPDN2  = 2'h3
  } pofc_tbmode_type;
  // fault handling states
  typedef enum logic [1:0] {
    FLT_RUN  = 2'h0,
    FLT_HOLD = 2'h1,
    FLT_WAIT = 2'h3
  } pofc_fault_type;
  // complete state of the top module
  typedef struct packed {
    logic [15:0]    ctl1;
    logic [15:0]    ctl2;
    logic [15:0]    ovr;
    logic [15:0]    ovr_act;
    logic [15:0]    flt;
    logic [15:0]    trig;
    logic           fault_flag;
    pofc_fault_type fst;
    logic           s1;
    logic           s2;
    logic [14:0]    prev_tmr;
    logic [3:0]     ps_cnt;
    logic [2:0]     sp_on;
    logic           en_q;
    logic           wreq;
    logic [31:0]    rdata;
    logic [2:0]     ph;
    logic [2:0]     phe;
    logic [2:0]     pl;
    logic [2:0]     ple;
    logic [2:0]     drv;
    logic           trig_out;
    logic           sp_end;
    logic           wake;
    logic           load_en;
  } pofc_state_type;
endpackage

/* File: rtl/pofc_top.sv */
// Purpose: PWM output stage: pair modes, single pulse, override,
//          polarity, pin enables, fault handling, lockout, trigger.
// Assumes: time base, duty compare and dead time sit outside; fault
//          input is asynchronous; polarity inputs are static.
// Notes:   Avalon-MM slave answers one cycle after a request.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pofc_map.svh"
module pofc_top (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [14:0] tb_timer,
  input  wire logic [14:0] tb_period,
  input  wire logic [1:0]  tb_mode,
  input  wire logic        tb_dir,
  input  wire logic        tb_enable,
  input  wire logic [2:0]  duty_cmp,
  input  wire logic [2:0]  duty_match,
  input  wire logic        period_match,
  input  wire logic [2:0]  dt_high,
  input  wire logic [2:0]  dt_low,
  input  wire logic        fault_input,
  input  wire logic        cpu_sleep,
  input  wire logic        high_side_polarity,
  input  wire logic        low_side_polarity,
  input  wire logic        reset_pin_state_fuse,
  output logic      [2:0]  high_side_output,
  output logic      [2:0]  high_side_oe,
  output logic      [2:0]  low_side_output,
  output logic      [2:0]  low_side_oe,
  output logic      [2:0]  pair_drive,
  output logic             adc_trigger,
  output logic             single_pulse_end,
  output logic             fault_flag,
  output logic             fault_wake,
  output logic             buffer_load_en
);
  pofc_pkg::pofc_state_type s;   // registered state
  pofc_pkg::pofc_state_type n;   // next state
  logic [31:0] rd;               // read mux
  logic        flow;             // synchronised fault is low
  logic        center;           // up/down counting mode
  logic        sp_mode;          // single-pulse mode
  logic        bnd;              // cycle or half-cycle boundary
  logic        wr_ok;            // write accepted this edge
  logic [2:0]  fen;              // fault enables per pair
  logic [2:0]  act_h;            // resolved high actives
  logic [2:0]  act_l;            // resolved low actives
  logic [2:0]  drv;              // drives toward dead time
  logic        hit;              // raw trigger match

  // only the second synchroniser stage is ever read
  assign flow    = ~s.s2;
  assign center  = tb_mode[0];
  assign sp_mode = (tb_mode == pofc_pkg::TB_SINGLE);
  assign bnd     = (tb_timer == 15'h0000) ||
                   (center && (tb_timer == tb_period));
  assign wr_ok   = avs_write && !s.wreq;
  assign fen     = s.flt[`POFC_FEN_LSB +: 3];
  // match only on a fresh timer value so a stalled timer fires once
  assign hit     = (tb_timer == s.trig[14:0]) &&
                   (tb_timer != s.prev_tmr) &&
                   (!center || (tb_dir == s.trig[`POFC_TDIR_BIT]));

  // one resolver per output pair
  for (genvar x = 0; x < 3; x++)
  begin : g_pair
    pofc_pair_if pi ();
    assign pi.indep  = s.ctl1[`POFC_PAIR_MODE_BIT_LSB + x];
    // single-pulse mode replaces the duty compare by the pulse latch
    assign pi.cmp    = sp_mode ? s.sp_on[x] : duty_cmp[x];
    assign pi.dt_h   = dt_high[x];
    assign pi.dt_l   = dt_low[x];
    assign pi.osel_l = s.ovr_act[`POFC_OSEL_LSB + 2 * x];
    assign pi.osel_h = s.ovr_act[`POFC_OSEL_LSB + 2 * x + 1];
    assign pi.olvl_l = s.ovr_act[`POFC_OLVL_LSB + 2 * x];
    assign pi.olvl_h = s.ovr_act[`POFC_OLVL_LSB + 2 * x + 1];
    // a pair is forced only when its own enable is set
    assign pi.fon    = fen[x] && (s.fst != pofc_pkg::FLT_RUN);
    assign pi.fst_l  = s.flt[`POFC_FST_LSB + 2 * x];
    assign pi.fst_h  = s.flt[`POFC_FST_LSB + 2 * x + 1];
    assign act_h[x]  = pi.act_h;
    assign act_l[x]  = pi.act_l;
    assign drv[x]    = pi.drive;
    pofc_pair u_pair (
      .p (pi)
    );
  end

  // byte-lane merge of a register write
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // next-state logic for bus, fault, trigger, pulse and pins
  always_comb
  begin
    n  = s;
    rd = 32'h0000_0000;
    n.s1       = fault_input;
    n.s2       = s.s1;
    n.wreq     = 1'b1;
    n.trig_out = 1'b0;
    n.sp_end   = 1'b0;
    n.en_q     = tb_enable;
    n.prev_tmr = tb_timer;
    // read decode; unmapped words read as zero
    if (avs_address == `POFC_A_CTL1)
      rd[15:0] = s.ctl1;
    else if (avs_address == `POFC_A_CTL2)
      rd[15:0] = s.ctl2;
    else if (avs_address == `POFC_A_OVR)
      rd[15:0] = s.ovr;
    else if (avs_address == `POFC_A_FLT)
      rd[15:0] = s.flt;
    else if (avs_address == `POFC_A_TRIG)
      rd[15:0] = s.trig;
    else if (avs_address == `POFC_A_STAT)
      rd[5:0] = {s.sp_on, s.fst != pofc_pkg::FLT_RUN, flow, s.fault_flag};
    // every request is answered exactly one cycle later
    if (s.wreq && (avs_read || avs_write))
    begin
      n.wreq  = 1'b0;
      n.rdata = rd;
    end
    // writes land at the edge where waitrequest is seen low
    if (wr_ok)
    begin
      if (avs_address == `POFC_A_CTL1)
        n.ctl1 = merge(s.ctl1, avs_writedata, avs_byteenable);
      else if (avs_address == `POFC_A_CTL2)
        n.ctl2 = merge(s.ctl2, avs_writedata, avs_byteenable);
      else if (avs_address == `POFC_A_OVR)
        n.ovr = merge(s.ovr, avs_writedata, avs_byteenable);
      else if (avs_address == `POFC_A_FLT)
        n.flt = merge(s.flt, avs_writedata, avs_byteenable);
      else if (avs_address == `POFC_A_TRIG)
        n.trig = merge(s.trig, avs_writedata, avs_byteenable);
    end
    // fault flag: a low input in the clearing cycle still sets it
    n.fault_flag = flow | (s.fault_flag & ~(wr_ok &&
                   avs_address == `POFC_A_STAT &&
                   avs_byteenable[0] &&
                   avs_writedata[`POFC_FLAG_BIT]));
    // fault low during sleep wakes the cpu
    n.wake = cpu_sleep & flow;
    // overrides apply at once, or at boundaries when synced
    if (!s.ctl2[`POFC_OVERRIDE_SYNC_BIT_BIT] || bnd)
      n.ovr_act = s.ovr;
    // fault sequencing
    case (s.fst)
      pofc_pkg::FLT_RUN:
        if (flow && (fen != 3'h0))
          n.fst = pofc_pkg::FLT_HOLD;
      pofc_pkg::FLT_HOLD:
        // latched waits for input high and a flag clear made while it is high
        if (!flow && (!s.flt[`POFC_FMODE_BIT] || !n.fault_flag))
          n.fst = pofc_pkg::FLT_WAIT;
      pofc_pkg::FLT_WAIT:
        if (flow)
          n.fst = pofc_pkg::FLT_HOLD;
        else if (bnd)
          n.fst = pofc_pkg::FLT_RUN;
      default:
        n.fst = pofc_pkg::FLT_RUN;
    endcase
    // disabling every pair releases the outputs at once
    if (fen == 3'h0)
      n.fst = pofc_pkg::FLT_RUN;
    // single pulse: start on enable, end on duty or period match
    if (sp_mode)
    begin
      if (tb_enable && !s.en_q)
        n.sp_on = 3'h7;
      n.sp_on = n.sp_on & ~duty_match;
      if (period_match)
      begin
        n.sp_on  = 3'h0;
        n.sp_end = 1'b1;
      end
    end
    else
      n.sp_on = 3'h0;
    // trigger postscaler; a compare write restarts the count
    if (wr_ok && (avs_address == `POFC_A_TRIG))
      n.ps_cnt = 4'h0;
    else if (hit)
    begin
      if (s.ps_cnt == s.ctl2[`POFC_OPS_LSB +: 4])
      begin
        n.trig_out = 1'b1;
        n.ps_cnt   = 4'h0;
      end
      else
        n.ps_cnt = s.ps_cnt + 4'h1;
    end
    // buffer transfers blocked while lockout is set
    n.load_en = ~s.ctl2[`POFC_UPDATE_LOCKOUT_BIT_BIT];
    // pin levels: active state mapped through each side's polarity
    n.ph  = ~(act_h ^ {3{high_side_polarity}});
    n.pl  = ~(act_l ^ {3{low_side_polarity}});
    n.phe = s.ctl1[`POFC_PENH_LSB +: 3];
    n.ple = s.ctl1[`POFC_PENL_LSB +: 3];
    n.drv = drv;
    // synchronous reset; the fuse is sampled here, on the clock
    if (rst)
    begin
      n            = '0;
      n.wreq       = 1'b1;
      n.s1         = 1'b1;
      n.s2         = 1'b1;
      n.ctl2       = `POFC_CTL2_RST;
      n.ovr        = `POFC_OVR_RST;
      n.ovr_act    = `POFC_OVR_RST;
      n.flt        = `POFC_FLT_RST;
      n.trig       = `POFC_TRIG_RST;
      n.fst        = pofc_pkg::FLT_RUN;
      n.load_en    = 1'b1;
      // fuse 0 drives inactive levels, fuse 1 releases the pins
      n.ctl1[`POFC_PENH_LSB +: 3] = {3{~reset_pin_state_fuse}};
      n.ctl1[`POFC_PENL_LSB +: 3] = {3{~reset_pin_state_fuse}};
      n.phe        = {3{~reset_pin_state_fuse}};
      n.ple        = {3{~reset_pin_state_fuse}};
      n.ph         = {3{~high_side_polarity}};
      n.pl         = {3{~low_side_polarity}};
    end
  end

  // single state register
  always_ff @(posedge ref_clk)
  begin
    s <= n;
  end

  // every output straight from the state register
  assign avs_readdata     = s.rdata;
  assign avs_waitrequest  = s.wreq;
  assign high_side_output = s.ph;
  assign high_side_oe     = s.phe;
  assign low_side_output  = s.pl;
  assign low_side_oe      = s.ple;
  assign pair_drive       = s.drv;
  assign adc_trigger      = s.trig_out;
  assign single_pulse_end = s.sp_end;
  assign fault_flag       = s.fault_flag;
  assign fault_wake       = s.wake;
  assign buffer_load_en   = s.load_en;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_sp_period_end: assert property (
    sp_mode && period_match |=> single_pulse_end && (s.sp_on == 3'h0))
    else $error("single pulse not ended by period match");
  chk_lockout_hold: assert property (
    s.ctl2[`POFC_UPDATE_LOCKOUT_BIT_BIT] |=> !buffer_load_en)
    else $error("buffer load allowed under lockout");
  chk_trig_clear: assert property (
    avs_write && !avs_waitrequest && (avs_address == `POFC_A_TRIG)
    |=> (s.ps_cnt == 4'h0) && !adc_trigger)
    else $error("postscaler not cleared by compare write");
  chk_fault_enter: assert property (
    (s.fst == pofc_pkg::FLT_RUN) && flow && (fen != 3'h0)
    |=> s.fst == pofc_pkg::FLT_HOLD)
    else $error("fault not entered");
  chk_fault_stays: assert property (
    (s.fst != pofc_pkg::FLT_RUN) && flow && (fen != 3'h0)
    |=> s.fst == pofc_pkg::FLT_HOLD)
    else $error("fault released while input low");
  chk_flag_sets: assert property (
    flow |=> fault_flag)
    else $error("fault flag missed a low input");
  chk_pin_release: assert property (
    !s.ctl1[`POFC_PENH_LSB] |=> !high_side_oe[0])
    else $error("disabled pin still driven");
  chk_wake_irq: assert property (
    cpu_sleep && flow |=> fault_wake)
    else $error("no wake on fault in sleep");
  chk_high_priority: assert property (
    (s.fst != pofc_pkg::FLT_RUN) && fen[0] &&
    !s.ctl1[`POFC_PAIR_MODE_BIT_LSB] |=>
    !((high_side_output[0] == high_side_polarity) &&
      (low_side_output[0] == low_side_polarity)))
    else $error("both pins active in complementary fault");
  chk_ovr_sync_wait: assert property (
    s.ctl2[`POFC_OVERRIDE_SYNC_BIT_BIT] && !bnd |=> $stable(s.ovr_act))
    else $error("override applied off boundary");
endmodule // pofc_top

/* File: sim/pofc_power_stage.sv */
// Purpose: power pairs and fault source beside the output stage.
// Assumes: one clock; the fault source moves just after an edge.
// Notes:   gates have no pull, so a released pin drifts each cycle.
`timescale 1ns/1ps
module pofc_power_stage (
  input  wire logic       ref_clk,
  input  wire logic [2:0] high_side_output,
  input  wire logic [2:0] high_side_oe,
  input  wire logic [2:0] low_side_output,
  input  wire logic [2:0] low_side_oe,
  input  wire logic       fault_req,
  output logic            fault_input,
  output logic      [2:0] hi_pin,
  output logic      [2:0] lo_pin
);
  logic [2:0] hi_last = 3'h0; // last level seen on each gate
  logic [2:0] lo_last = 3'h0;
  // remember levels so a floating gate never looks driven
  always @(posedge ref_clk)
  begin
    hi_last <= hi_pin;
    lo_last <= lo_pin;
  end
  // driven gate follows the stage, released gate inverts
  assign hi_pin = (high_side_oe & high_side_output) |
                  (~high_side_oe & ~hi_last);
  assign lo_pin = (low_side_oe & low_side_output) | (~low_side_oe & ~lo_last);
  // trouble pulls the line low until the source lets go
  assign fault_input = ~fault_req;
endmodule // pofc_power_stage

/* File: sim/tb_pofc_top.sv */
// Purpose: self-checking bench of the PWM output stage.
// Assumes: high pins active high, low pins active low.
// Notes:   fixed seed; corner cases among the random values.
`timescale 1ns/1ps
module tb_pofc_top;
  logic        ref_clk = 1'b0;   // 25 MHz
  logic        rst = 1'b1;       // synchronous reset
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [14:0] tb_timer = 15'h0;
  logic [14:0] tb_period = 15'h000F; // ramps run 0..15
  logic [1:0]  tb_mode = 2'h0;
  logic        tb_dir = 1'b0;
  logic        tb_enable = 1'b0;
  logic [2:0]  duty_cmp = 3'h0;
  logic [2:0]  duty_match = 3'h0;
  logic        period_match = 1'b0;
  logic [2:0]  dt_high = 3'h0;
  logic [2:0]  dt_low = 3'h0;
  logic        fault_input;
  logic        fault_req = 1'b0;  // 1 = partner signals trouble
  logic        cpu_sleep = 1'b0;
  logic        high_side_polarity = 1'b1;
  logic        low_side_polarity = 1'b0;
  logic        reset_pin_state_fuse = 1'b1;
  logic [2:0]  high_side_output, high_side_oe, low_side_output;
  logic [2:0]  low_side_oe, pair_drive, hi_pin, lo_pin;
  logic        adc_trigger, single_pulse_end, fault_flag;
  logic        fault_wake, buffer_load_en;
  int          miscompares = 0;
  int          num_checks = 0;
  int          trig_cnt = 0;     // adc trigger pulses seen
  int          sp_cnt = 0;       // single pulse end pulses seen
  int          n0;
  integer      seed = 32'h6F43;
  logic [15:0] ov;
  logic [2:0]  c;
  logic [3:0]  ps;
  pofc_top i_pofc_top (.ref_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .tb_timer, .tb_period, .tb_mode, .tb_dir,
    .tb_enable, .duty_cmp, .duty_match, .period_match, .dt_high,
    .dt_low, .fault_input, .cpu_sleep, .high_side_polarity,
    .low_side_polarity, .reset_pin_state_fuse, .high_side_output,
    .high_side_oe, .low_side_output, .low_side_oe, .pair_drive,
    .adc_trigger, .single_pulse_end, .fault_flag, .fault_wake,
    .buffer_load_en);
  pofc_power_stage i_pofc_power_stage (.ref_clk, .high_side_output,
    .high_side_oe, .low_side_output, .low_side_oe, .fault_req,
    .fault_input, .hi_pin, .lo_pin);
  // clock generator
  initial
    forever #20 ref_clk = ~ref_clk;
  // pulse counters, so latency of one-cycle outputs does not matter
  always @(posedge ref_clk)
  begin
    if (adc_trigger === 1'b1)
      trig_cnt <= trig_cnt + 1;
    if (single_pulse_end === 1'b1)
      sp_cnt <= sp_cnt + 1;
  end
  // compare one value, report at once
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one Avalon transfer; held until waitrequest is seen low
  task automatic bus(logic w, logic [2:0] a, logic [15:0] d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {16'h0, d};
    avs_byteenable <= 4'h3;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wreg(logic [2:0] a, logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(string s, logic [2:0] a, logic [31:0] m, logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 16'h0, q);
    check(s, q & m, e);
  endtask
  // n edges, then stop mid-cycle where outputs are settled
  task automatic settle(int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // active states of all pins through the polarity in use
  task automatic pins(logic [2:0] h, logic [2:0] l);
    check("high pins", 32'(high_side_output), 32'(h));
    check("low pins", 32'(low_side_output), 32'(l ^ 3'h7));
  endtask
  // a timer boundary, then leave the timer off it
  task automatic tzero();
    @(posedge ref_clk);
    tb_timer <= 15'h0;
    @(posedge ref_clk);
    tb_timer <= 15'h1;
  endtask
  task automatic ramp(int n, logic ud);
    for (int r = 0; r < n; r++)
    begin
      for (int t = 0; t < 16; t++)
      begin
        @(posedge ref_clk);
        tb_timer <= 15'(t);
        tb_dir <= 1'b0;
      end
      for (int t = 15; t >= 0 && ud; t--)
      begin
        @(posedge ref_clk);
        tb_timer <= 15'(t);
        tb_dir <= 1'b1;
      end
    end
  endtask
  // expected active state of one side from override bits and compare
  function automatic logic [2:0] act(logic [15:0] v, logic [2:0] cm, int hi);
    logic [2:0] s;
    logic [2:0] l;
    s = {v[12 + hi], v[10 + hi], v[8 + hi]};
    l = {v[4 + hi], v[2 + hi], v[hi]};
    return (s & l) | (~s & cm);
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog, far beyond the few thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    settle(1);
    check("oe", 32'({high_side_oe, low_side_oe}), 32'h0);
    for (int i = 0; i < 7; i++)
      rchk("reset value", 3'(i), 32'hFFFF, 32'h0);
    wreg(3'h6, 16'hFFFF);
    rchk("unmapped", 3'h6, 32'hFFFFFFFF, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      ov = 16'($random(seed));
      wreg(3'h2, ov);
      rchk("override", 3'h2, 32'h3F3F, 32'(ov & 16'h3F3F));
    end
    wreg(3'h0, 16'h0777);
    for (int i = 0; i < 8; i++)
    begin
      ov = (i == 0) ? 16'h0 : 16'($random(seed));
      c = (i == 0) ? 3'h7 : 3'($random(seed));
      wreg(3'h2, ov);
      duty_cmp <= c;
      settle(3);
      pins(act(ov, c, 1), act(ov, c, 0));
    end
    wreg(3'h0, 16'h0725);
    settle(3);
    check("pin enables", 32'({high_side_oe, low_side_oe}), 32'h15);
    wreg(3'h0, 16'h0077);
    @(posedge ref_clk);
    duty_cmp <= 3'h6;
    dt_high <= 3'($random(seed));
    dt_low <= 3'($random(seed));
    for (int i = 0; i < 3; i++)
    begin
      ov = (i == 0) ? 16'h0202 : (i == 1) ? 16'h0200 : 16'h0101;
      wreg(3'h2, ov);
      settle(3);
      check("drive", 32'(pair_drive), 32'({2'h3, i == 0}));
      pins(dt_high, dt_low);
    end
    wreg(3'h0, 16'h0777);
    duty_cmp <= 3'h0;
    tb_timer <= 15'h5;
    wreg(3'h2, 16'h0);
    wreg(3'h1, 16'h0002);
    wreg(3'h2, 16'h3F3F);
    settle(3);
    pins(3'h0, 3'h0);
    tzero();
    settle(3);
    pins(3'h7, 3'h7);
    wreg(3'h2, 16'h3F00);
    tb_mode <= 2'h1;
    settle(3);
    pins(3'h7, 3'h7);
    @(posedge ref_clk);
    tb_timer <= tb_period;
    settle(3);
    pins(3'h0, 3'h0);
    wreg(3'h1, 16'h0);
    tb_mode <= 2'h0;
    tb_timer <= 15'h5;
    wreg(3'h2, 16'h0);
    wreg(3'h0, 16'h0377);
    dt_high <= 3'h0;
    dt_low <= 3'h0;
    wreg(3'h3, 16'h3600);
    fault_req <= 1'b1;
    settle(6);
    pins(3'h0, 3'h0);
    check("flag", 32'(fault_flag), 32'h1);
    @(posedge ref_clk);
    fault_req <= 1'b0;
    wreg(3'h5, 16'h0001);
    wreg(3'h3, 16'h3607);
    fault_req <= 1'b1;
    settle(6);
    pins(3'h5, 3'h2);
    @(posedge ref_clk);
    fault_req <= 1'b0;
    settle(6);
    pins(3'h5, 3'h2);
    tzero();
    settle(4);
    pins(3'h0, 3'h0);
    wreg(3'h5, 16'h0001);
    wreg(3'h3, 16'hB607);
    fault_req <= 1'b1;
    cpu_sleep <= 1'b1;
    settle(6);
    check("wake", 32'(fault_wake), 32'h1);
    @(posedge ref_clk);
    fault_req <= 1'b0;
    cpu_sleep <= 1'b0;
    tzero();
    settle(4);
    pins(3'h5, 3'h2);
    check("flag", 32'(fault_flag), 32'h1);
    wreg(3'h5, 16'h0001);
    settle(2);
    pins(3'h5, 3'h2);
    tzero();
    settle(4);
    pins(3'h0, 3'h0);
    wreg(3'h1, 16'h0001);
    settle(2);
    check("load enable", 32'(buffer_load_en), 32'h0);
    wreg(3'h1, 16'h0);
    settle(2);
    check("load enable", 32'(buffer_load_en), 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      ps = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 :
           (k == 2) ? 4'hF : 4'($random(seed));
      wreg(3'h1, {4'h0, ps, 8'h0});
      wreg(3'h4, 16'h0009);
      n0 = trig_cnt;
      ramp(17, 1'b0);
      settle(3);
      check("triggers", 32'(trig_cnt - n0), 17 / (ps + 1));
    end
    wreg(3'h1, 16'h0);
    for (int k = 0; k < 3; k++)
    begin
      wreg(3'h4, (k == 1) ? 16'h0009 : 16'h8009);
      // both up/down modes, then free running where direction is ignored
      tb_mode <= (k == 2) ? 2'h0 : 2'(2 * k + 1);
      n0 = trig_cnt;
      ramp(4, 1'b1);
      settle(3);
      check("phase triggers", trig_cnt - n0, (k == 2) ? 32'h8 : 32'h4);
    end
    wreg(3'h0, 16'h0777);
    tb_mode <= 2'h2;
    tb_timer <= 15'h1;
    settle(3);
    pins(3'h0, 3'h0);
    @(posedge ref_clk);
    tb_enable <= 1'b1;
    settle(3);
    pins(3'h7, 3'h7);
    @(posedge ref_clk);
    duty_match <= 3'h1;
    @(posedge ref_clk);
    duty_match <= 3'h0;
    settle(3);
    pins(3'h6, 3'h6);
    n0 = sp_cnt;
    @(posedge ref_clk);
    period_match <= 1'b1;
    @(posedge ref_clk);
    period_match <= 1'b0;
    settle(3);
    pins(3'h0, 3'h0);
    check("pulse end", 32'(sp_cnt - n0), 32'h1);
    @(posedge ref_clk);
    tb_enable <= 1'b0;
    reset_pin_state_fuse <= 1'b0;
    rst <= 1'b1;
    settle(5);
    check("oe", 32'({high_side_oe, low_side_oe}), 32'h3F);
    pins(3'h0, 3'h0);
    check("gates", 32'({hi_pin, lo_pin}), 32'h07);
    @(posedge ref_clk);
    rst <= 1'b0;
    rchk("enables", 3'h0, 32'h0077, 32'h0077);
    close_out();
  end
endmodule // tb_pofc_top
